// [hw/tsmc_ctrl.sv]
// Purpose: serial slave port and operating-mode sequencing of the transceiver
// Assumes: serial pins are asynchronous and slow (8 MHz at most) against the core clock
// Notes:   write payload leaves as 16-bit words through a FIFO; reads use a lookup port
module tsmc_ctrl #(
	parameter int OFF_WAKE  = tsmc_pkg::OFF_WAKE_CYCLES,
	parameter int HIB_WAKE  = tsmc_pkg::HIB_WAKE_CYCLES,
	parameter int DOZE_WAKE = tsmc_pkg::DOZE_WAKE_CYCLES,
	parameter int RXTX_WARM = tsmc_pkg::RXTX_WARM_CYCLES
) (
	// core clock and hardware reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// serial port pins
	input  wire logic                 serial_shift_clock,
	input  wire logic                 select_n,
	input  wire logic                 mosi,
	output logic                      miso,
	output logic                      miso_oe,
	// wake and clock output pins
	input  wire logic                 wake_attention_n,
	output logic                      host_clock_output,
	output logic                      host_clock_output_oe,
	// interrupt request pin, released in off
	input  wire logic                 irq_request,
	output logic                      irq_n,
	output logic                      irq_oe,
	// core side events
	input  wire logic                 timer_match,
	input  wire logic                 seq_done,
	// core side write words
	output logic                      wr_valid,
	input  wire logic                 wr_ready,
	output tsmc_pkg::tsmc_word_t      wr_word,
	output logic                      wr_dropped,
	// core side read lookup
	output logic [5:0]                rd_addr,
	output logic                      rd_strobe,
	input  wire logic [15:0]          rd_data,
	// mode status
	output tsmc_pkg::tsmc_mode_t      mode
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	tsmc_pkg::tsmc_mode_t     mode_q;
	tsmc_pkg::tsmc_clk_ctrl_t clk_ctrl_q;
	logic [tsmc_pkg::WAIT_W-1:0] wait_q;
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic       sclk_prev_q;
	logic       sel_prev_q;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       frame_start;
	logic       frame_end;
	logic       frame_ok_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] burst_cnt_q;
	logic [7:0] shift_in_q;
	logic [7:0] byte_in;
	logic       byte_done;
	logic       is_read_q;
	logic [5:0] addr_q;
	logic [7:0] hi_byte_q;
	logic [7:0] out_sh_q;
	logic [7:0] lo_out_q;
	logic [15:0] rd_word;
	logic       mode_pend_q;
	logic [2:0] mode_cmd_q;
	logic       ctrl_pend_q;
	logic [15:0] ctrl_word_q;
	logic       push_valid_q;
	tsmc_pkg::tsmc_word_t push_word_q;
	logic       push_ready;
	logic       frame_apply;
	logic [tsmc_pkg::WAIT_W-1:0] host_clock_output_half;
	logic [tsmc_pkg::WAIT_W-1:0] host_clock_output_cnt_q;
	logic       host_clock_output_q;
	logic       host_clock_output_oe_q;
	logic       host_clock_output_slow;
	logic       wake_req;
	logic       miso_q;
	logic       miso_oe_q;
	logic       irq_n_q;
	logic       irq_oe_q;
	logic       rd_strobe_q;
	logic       dropped_q;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: clock, select, data, attention
	// pins only sampled
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 4'hE;  // serial clock bit starts at its idle low level
			sync_q <= 4'hE;
		end else begin
			meta_q <= {wake_attention_n, mosi, select_n, serial_shift_clock};
			sync_q <= meta_q;
		end
	end

	// edge history on the synchronised pins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
			sel_prev_q  <= 1'b1;
		end else begin
			sclk_prev_q <= sync_q[0];
			sel_prev_q  <= sync_q[1];
		end
	end

	assign sclk_rise   = sync_q[0] && !sclk_prev_q && !sync_q[1];
	assign sclk_fall   = !sync_q[0] && sclk_prev_q && !sync_q[1];
	assign frame_start = !sync_q[1] && sel_prev_q;
	assign frame_end   = sync_q[1] && !sel_prev_q;
	assign byte_in     = {shift_in_q[6:0], sync_q[2]};
	assign byte_done   = sclk_rise && frame_ok_q && (bit_cnt_q == 3'h7);
	assign frame_apply = frame_end && frame_ok_q && !is_read_q
		&& (burst_cnt_q >= 8'(tsmc_pkg::MIN_BURSTS)) && burst_cnt_q[0];
	assign wake_req    = !sync_q[3] || (timer_match && clk_ctrl_q.tmr_wake_en
		&& mode_q == tsmc_pkg::TSMC_DOZE);

	////////////////////////////////////////////////////////////////////////////////
	// frame state and input shifter
	// frames accepted in idle only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_ok_q  <= 1'b0;
			bit_cnt_q   <= 3'h0;
			burst_cnt_q <= 8'h00;
			shift_in_q  <= 8'h00;
		end else if (frame_start) begin
			frame_ok_q  <= (mode_q == tsmc_pkg::TSMC_IDLE);
			bit_cnt_q   <= 3'h0;
			burst_cnt_q <= 8'h00;
		end else if (sync_q[1]) begin
			frame_ok_q <= 1'b0;
		end else if (sclk_rise && frame_ok_q) begin
			shift_in_q <= byte_in;
			bit_cnt_q  <= bit_cnt_q + 3'h1;
			if (bit_cnt_q == 3'h7 && burst_cnt_q != 8'hFF) begin
				burst_cnt_q <= burst_cnt_q + 8'h01;
			end
		end
	end

	// header decode and write pairing
	// header gives direction and address
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			is_read_q <= 1'b0;
			addr_q    <= 6'h00;
			hi_byte_q <= 8'h00;
		end else if (byte_done) begin
			if (burst_cnt_q == 8'h00) begin
				is_read_q <= byte_in[tsmc_pkg::HDR_READ_BIT];
				addr_q    <= byte_in[tsmc_pkg::ADDR_W-1:0];
			end else if (burst_cnt_q[0]) begin
				hi_byte_q <= byte_in;
			end
		end
	end

	// completed write words toward the FIFO, held until taken
	// write payload on mosi only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			push_valid_q <= 1'b0;
			push_word_q  <= '0;
			dropped_q    <= 1'b0;
		end else begin
			if (push_valid_q && push_ready) push_valid_q <= 1'b0;
			if (byte_done && !is_read_q && burst_cnt_q != 8'h00 && !burst_cnt_q[0]) begin
				if (push_valid_q && !push_ready) begin
					dropped_q <= 1'b1;  // previous word still waiting: this one is lost
				end else begin
					push_valid_q     <= 1'b1;
					push_word_q.addr <= addr_q;
					push_word_q.data <= {hi_byte_q, byte_in};
				end
			end
		end
	end

	// words for the block itself wait for a complete frame
	// mode change out of idle only by serial command
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_pend_q <= 1'b0;
			mode_cmd_q  <= tsmc_pkg::CMD_IDLE;
			ctrl_pend_q <= 1'b0;
			ctrl_word_q <= 16'h0000;
		end else if (frame_start) begin
			mode_pend_q <= 1'b0;
			ctrl_pend_q <= 1'b0;
		end else if (byte_done && !is_read_q && burst_cnt_q == 8'h02) begin
			if (addr_q == tsmc_pkg::MODE_ADDR) begin
				mode_pend_q <= 1'b1;
				mode_cmd_q  <= byte_in[2:0];
			end else if (addr_q == tsmc_pkg::CLK_CTRL_ADDR) begin
				ctrl_pend_q <= 1'b1;
				ctrl_word_q <= {hi_byte_q, byte_in};
			end
		end
	end

	// clock output control, kept through hibernate and doze
	// defaults after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clk_ctrl_q.host_clock_output_doze_en <= 1'b0;
			clk_ctrl_q.tmr_wake_en  <= 1'b0;
			clk_ctrl_q.host_clock_output_sel     <= tsmc_pkg::HOST_CLOCK_OUTPUT_SEL_RST;
		end else if (frame_apply && ctrl_pend_q) begin
			clk_ctrl_q.host_clock_output_doze_en <= ctrl_word_q[tsmc_pkg::HOST_CLOCK_OUTPUT_DOZE_BIT];
			clk_ctrl_q.tmr_wake_en  <= ctrl_word_q[tsmc_pkg::TMR_WAKE_BIT];
			clk_ctrl_q.host_clock_output_sel     <= ctrl_word_q[tsmc_pkg::HOST_CLOCK_OUTPUT_SEL_LSB +: 3];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read payload source: mode status at the mode address, else the lookup port
	always_comb begin
		rd_word = rd_data;
		if (addr_q == tsmc_pkg::MODE_ADDR) rd_word = {12'h000, mode_q};
	end

	// output shifter: loads a byte at each byte boundary, shifts on falling clock
	// core clock moves data to the serial register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_sh_q    <= 8'h00;
			lo_out_q    <= 8'h00;
			miso_q      <= 1'b0;
			rd_strobe_q <= 1'b0;
		end else begin
			rd_strobe_q <= 1'b0;
			if (sclk_fall && frame_ok_q && is_read_q && burst_cnt_q != 8'h00) begin
				if (bit_cnt_q == 3'h0 && burst_cnt_q[0]) begin
					miso_q      <= rd_word[15];
					out_sh_q    <= {rd_word[14:8], 1'b0};
					lo_out_q    <= rd_word[7:0];
					rd_strobe_q <= 1'b1;
				end else if (bit_cnt_q == 3'h0) begin
					miso_q   <= lo_out_q[7];
					out_sh_q <= {lo_out_q[6:0], 1'b0};
				end else begin
					miso_q   <= out_sh_q[7];
					out_sh_q <= {out_sh_q[6:0], 1'b0};
				end
			end
		end
	end

	// data out enable
	// miso driven only in read payload
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			miso_oe_q <= 1'b0;
		end else begin
			miso_oe_q <= frame_ok_q && !sync_q[1] && is_read_q && burst_cnt_q != 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// operating mode sequencer with one wait counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= tsmc_pkg::TSMC_OFF;
			wait_q <= tsmc_pkg::WAIT_W'(OFF_WAKE);
		end else begin
			if (wait_q != '0) wait_q <= wait_q - 1'b1;
			case (mode_q)
				tsmc_pkg::TSMC_OFF: begin
					if (wait_q == '0) mode_q <= tsmc_pkg::TSMC_IDLE;
				end
				tsmc_pkg::TSMC_IDLE: begin
					if (frame_apply && mode_pend_q) begin
						case (mode_cmd_q)
							tsmc_pkg::CMD_DOZE: mode_q <= tsmc_pkg::TSMC_DOZE;
							tsmc_pkg::CMD_HIBERNATE: mode_q <= tsmc_pkg::TSMC_HIBERNATE;
							tsmc_pkg::CMD_RECEIVE: begin
								mode_q <= tsmc_pkg::TSMC_RX_WARM;
								wait_q <= tsmc_pkg::WAIT_W'(RXTX_WARM);
							end
							tsmc_pkg::CMD_TRANSMIT: begin
								mode_q <= tsmc_pkg::TSMC_TX_WARM;
								wait_q <= tsmc_pkg::WAIT_W'(RXTX_WARM);
							end
							default: mode_q <= tsmc_pkg::TSMC_IDLE;
						endcase
					end
				end
				tsmc_pkg::TSMC_HIBERNATE: begin
					if (!sync_q[3]) begin
						mode_q <= tsmc_pkg::TSMC_HIB_WAKE;
						wait_q <= tsmc_pkg::WAIT_W'(HIB_WAKE);
					end
				end
				tsmc_pkg::TSMC_HIB_WAKE: begin
					if (wait_q == '0) mode_q <= tsmc_pkg::TSMC_IDLE;
				end
				// doze wake time plus one output period
				tsmc_pkg::TSMC_DOZE: begin
					if (wake_req) begin
						mode_q <= tsmc_pkg::TSMC_DOZE_WAKE;
						wait_q <= tsmc_pkg::WAIT_W'(DOZE_WAKE) + {host_clock_output_half[tsmc_pkg::WAIT_W-2:0], 1'b0};
					end
				end
				tsmc_pkg::TSMC_DOZE_WAKE: begin
					if (wait_q == '0) mode_q <= tsmc_pkg::TSMC_IDLE;
				end
				tsmc_pkg::TSMC_RX_WARM: begin
					if (wait_q == '0) mode_q <= tsmc_pkg::TSMC_RECEIVE;
				end
				tsmc_pkg::TSMC_TX_WARM: begin
					if (wait_q == '0) mode_q <= tsmc_pkg::TSMC_TRANSMIT;
				end
				tsmc_pkg::TSMC_RECEIVE, tsmc_pkg::TSMC_TRANSMIT: begin
					if (seq_done) mode_q <= tsmc_pkg::TSMC_IDLE;
				end
				default: mode_q <= tsmc_pkg::TSMC_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// clock output divider and enable
	// shift amount kept at four bits so the slowest selects do not wrap
	assign host_clock_output_half = tsmc_pkg::WAIT_W'(1)
		<< (4'(clk_ctrl_q.host_clock_output_sel) + 4'(tsmc_pkg::HOST_CLOCK_OUTPUT_SHIFT));
	assign host_clock_output_slow = (clk_ctrl_q.host_clock_output_sel >= tsmc_pkg::HOST_CLOCK_OUTPUT_SEL_SLOW);

	// idle drives the clock output; doze only when enabled and slow
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			host_clock_output_cnt_q <= '0;
			host_clock_output_q     <= 1'b0;
			host_clock_output_oe_q  <= 1'b0;
		end else begin
			if (host_clock_output_cnt_q >= host_clock_output_half - 1'b1) begin
				host_clock_output_cnt_q <= '0;
				host_clock_output_q     <= !host_clock_output_q;
			end else begin
				host_clock_output_cnt_q <= host_clock_output_cnt_q + 1'b1;
			end
			case (mode_q)
				tsmc_pkg::TSMC_OFF: host_clock_output_oe_q <= 1'b0;
				tsmc_pkg::TSMC_DOZE: host_clock_output_oe_q <= clk_ctrl_q.host_clock_output_doze_en && host_clock_output_slow;
				tsmc_pkg::TSMC_HIBERNATE, tsmc_pkg::TSMC_HIB_WAKE: host_clock_output_oe_q <= 1'b1;
				default: host_clock_output_oe_q <= 1'b1;
			endcase
		end
	end

	// interrupt pin, released in off
	// all outputs released in off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_n_q  <= 1'b1;
			irq_oe_q <= 1'b0;
		end else begin
			irq_n_q  <= !irq_request;
			irq_oe_q <= (mode_q != tsmc_pkg::TSMC_OFF);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write word FIFO
	tsmc_fifo #(
		.WIDTH ($bits(tsmc_pkg::tsmc_word_t)),
		.DEPTH (tsmc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (push_valid_q),
		.in_ready  (push_ready),
		.in_data   (push_word_q),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign miso                 = miso_q;
	assign miso_oe              = miso_oe_q;
	assign host_clock_output    = host_clock_output_q && (mode_q != tsmc_pkg::TSMC_HIBERNATE)
		&& (mode_q != tsmc_pkg::TSMC_HIB_WAKE);
	assign host_clock_output_oe = host_clock_output_oe_q;
	assign irq_n                = irq_n_q;
	assign irq_oe               = irq_oe_q;
	assign wr_dropped           = dropped_q;
	assign rd_addr              = addr_q;
	assign rd_strobe            = rd_strobe_q;
	assign mode                 = mode_q;
endmodule

// [hw/tsmc_fifo.sv]
// Purpose: small flip-flop FIFO between the serial write path and the core side
// Assumes: one clock, asynchronous active-low reset
// Notes:   depth must be a power of two
module tsmc_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [PW:0]      cnt_q;
	logic             push;
	logic             pop;

	// handshakes on both sides
	assign in_ready  = (cnt_q != DEPTH[PW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
			if (push && !pop) cnt_q <= cnt_q + 1'b1;
			else if (pop && !push) cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// [hw/tsmc_pkg.sv]
// Purpose: shared constants and types of the transceiver serial port and mode control
// Assumes: core clock of 100 MHz drives every register of the block
// Notes:   times are kept in their own unit, cycle counts are derived from them
package tsmc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and transition times
	localparam int CLK_MHZ          = 100;
	localparam int OFF_WAKE_MS      = 10;   // least time from reset release to idle
	localparam int HIB_WAKE_MS      = 7;    // least time from hibernate to idle
	localparam int DOZE_WAKE_US     = 300;  // doze to idle, before the extra clock period
	localparam int RXTX_WARM_US     = 144;  // idle to receive or transmit
	localparam int OFF_WAKE_CYCLES  = OFF_WAKE_MS * 1000 * CLK_MHZ;
	localparam int HIB_WAKE_CYCLES  = HIB_WAKE_MS * 1000 * CLK_MHZ;
	localparam int DOZE_WAKE_CYCLES = DOZE_WAKE_US * CLK_MHZ;
	localparam int RXTX_WARM_CYCLES = RXTX_WARM_US * CLK_MHZ;
	localparam int WAIT_W           = 24;

	////////////////////////////////////////////////////////////////////////////////
	// serial frame layout
	localparam int      HDR_READ_BIT    = 7;     // header bit set for a read
	localparam int      ADDR_W          = 6;
	localparam int      MIN_BURSTS      = 3;     // header plus two payload bytes
	localparam int      FIFO_DEPTH      = 4;

	////////////////////////////////////////////////////////////////////////////////
	// internal resource addresses and fields decoded by the block
	localparam logic [5:0] MODE_ADDR     = 6'h00; // write: mode command, read: mode status
	localparam logic [5:0] CLK_CTRL_ADDR = 6'h07; // clock output control
	localparam int         HOST_CLOCK_OUTPUT_DOZE_BIT = 9;     // clock output kept alive in doze, at selects 3 and above only
	localparam int         TMR_WAKE_BIT  = 8;     // timer comparator may end doze
	localparam int         HOST_CLOCK_OUTPUT_SEL_LSB  = 0;     // 3-bit divider select
	localparam logic [2:0] HOST_CLOCK_OUTPUT_SEL_RST  = 3'h7;
	localparam logic [2:0] HOST_CLOCK_OUTPUT_SEL_SLOW = 3'h3;  // this and above give 1 MHz or less
	localparam int         HOST_CLOCK_OUTPUT_SHIFT    = 3;     // half period is 2^(sel+3) cycles

	// mode command codes in the low bits of a mode write
	localparam logic [2:0] CMD_IDLE      = 3'h0;
	localparam logic [2:0] CMD_DOZE      = 3'h1;
	localparam logic [2:0] CMD_HIBERNATE = 3'h2;
	localparam logic [2:0] CMD_RECEIVE   = 3'h3;
	localparam logic [2:0] CMD_TRANSMIT  = 3'h4;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [3:0] {
		TSMC_OFF,
		TSMC_IDLE,
		TSMC_HIBERNATE,
		TSMC_HIB_WAKE,
		TSMC_DOZE,
		TSMC_DOZE_WAKE,
		TSMC_RX_WARM,
		TSMC_RECEIVE,
		TSMC_TX_WARM,
		TSMC_TRANSMIT
	} tsmc_mode_t;

	typedef struct packed {
		logic [5:0]  addr;
		logic [15:0] data;
	} tsmc_word_t;

	typedef struct packed {
		logic host_clock_output_doze_en;
		logic tmr_wake_en;
		logic [2:0] host_clock_output_sel;
	} tsmc_clk_ctrl_t;

endpackage

// [test/tsmc_ctrl_bench.sv]
// Purpose: self-checking bench of the serial port and mode control
// Assumes: host model drives the serial pins, the bench the rest at falling edges
// Notes:   transition counts are shortened through the design parameters
module tsmc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OFFW = 40;
	localparam int HIBW = 30;
	localparam int DOZW = 20;
	localparam int WARM = 25;

	logic                 clock, rst_n, serial_shift_clock, select_n, mosi, miso, miso_oe;
	logic                 wake_attention_n, host_clock_output, host_clock_output_oe;
	logic                 irq_request, irq_n, irq_oe, timer_match, seq_done;
	logic                 wr_valid, wr_ready, wr_dropped, rd_strobe;
	logic [5:0]           rd_addr, a;
	logic [15:0]          rd_data;
	logic [15:0]          d [5];
	logic [31:0]          rd;
	tsmc_pkg::tsmc_word_t wr_word;
	tsmc_pkg::tsmc_mode_t mode, m;
	int                   fails, checks, seed, i;

	// design, host model and read lookup
	tsmc_ctrl #(.OFF_WAKE(OFFW), .HIB_WAKE(HIBW), .DOZE_WAKE(DOZW), .RXTX_WARM(WARM)) uut (
		.clock, .rst_n, .serial_shift_clock, .select_n, .mosi, .miso, .miso_oe,
		.wake_attention_n, .host_clock_output, .host_clock_output_oe, .irq_request, .irq_n,
		.irq_oe, .timer_match, .seq_done, .wr_valid, .wr_ready, .wr_word, .wr_dropped,
		.rd_addr, .rd_strobe, .rd_data, .mode);
	tsmc_host host (.serial_shift_clock, .select_n, .mosi, .miso, .miso_oe);
	assign rd_data = rd_fn(rd_addr);

	// clock and random interrupt level
	always #5 clock = ~clock;
	always @(negedge clock) if (rst_n) irq_request <= 1'($random(seed));

	////////////////////////////////////////////////
	function automatic logic [15:0] rd_fn(input logic [5:0] ad);
		return {ad, ~ad, 4'hA};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_mode(input tsmc_pkg::tsmc_mode_t w, input int lim);
		int n;
		n = 0;
		while (mode !== w && n < lim) begin
			@(negedge clock);
			n++;
		end
		chk(mode, w);
		if (mode !== w) end_sim();
	endtask

	task automatic xfer(input logic [7:0] hdr, input logic [31:0] pay, input int nb);
		host.frame(hdr, pay, nb, rd);
		@(negedge clock);
	endtask

	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence
	initial begin
		seed = 37685;
		fails = 0;
		checks = 0;
		clock = 0;
		rst_n = 0;
		wake_attention_n = 1;
		irq_request = 0;
		timer_match = 0;
		seq_done = 0;
		wr_ready = 1;
		repeat (16) @(negedge clock);
		chk(mode, tsmc_pkg::TSMC_OFF);
		chk({miso_oe, irq_oe, host_clock_output_oe}, 0);
		rst_n = 1;
		wait_mode(tsmc_pkg::TSMC_IDLE, OFFW + 10);
		repeat (4) @(negedge clock);
		chk(host_clock_output_oe, 1);
		xfer(8'h80, 0, 2);
		chk(rd[15:0], {12'h0, tsmc_pkg::TSMC_IDLE});
		for (i = 0; i < 4; i++) begin
			a = 6'($random(seed)) | 6'h08;
			host.half = (i == 0) ? 200 : 80;
			xfer({2'b10, a}, 0, 2);
			chk(rd[15:0], rd_fn(a));
			chk(miso_oe, 0);
		end
		// clock out kept in doze, timer wake, divider 3
		xfer({2'b00, tsmc_pkg::CLK_CTRL_ADDR}, {16'h0303, 16'h0}, 2);
		xfer(8'h00, {8'h01, 24'h0}, 1);
		xfer(8'h00, {16'h0001, 16'h0}, 3);
		chk(mode, tsmc_pkg::TSMC_IDLE);
		xfer(8'h00, {16'h0001, 16'h0}, 2);
		wait_mode(tsmc_pkg::TSMC_DOZE, 20);
		repeat (4) @(negedge clock);
		chk(host_clock_output_oe, 1);
		xfer({2'b00, tsmc_pkg::CLK_CTRL_ADDR}, 0, 2);
		chk(mode, tsmc_pkg::TSMC_DOZE);
		repeat (4) @(negedge clock);
		chk(host_clock_output_oe, 1);
		timer_match = 1;
		@(negedge clock);
		timer_match = 0;
		wait_mode(tsmc_pkg::TSMC_DOZE_WAKE, 5);
		repeat (DOZW + 100) @(negedge clock);
		chk(mode, tsmc_pkg::TSMC_DOZE_WAKE);
		wait_mode(tsmc_pkg::TSMC_IDLE, 60);
		// receive then transmit
		for (i = 0; i < 2; i++) begin
			m = tsmc_pkg::tsmc_mode_t'(tsmc_pkg::TSMC_RX_WARM + 2 * i);
			xfer(8'h00, {13'h0, 3'(tsmc_pkg::CMD_RECEIVE + i), 16'h0}, 2);
			wait_mode(m, 20);
			repeat (WARM - 12) @(negedge clock);
			chk(mode, m);
			wait_mode(tsmc_pkg::tsmc_mode_t'(m + 1), 12);
			seq_done = 1;
			@(negedge clock);
			seq_done = 0;
			wait_mode(tsmc_pkg::TSMC_IDLE, 5);
		end
		xfer(8'h00, {16'h0002, 16'h0}, 2);
		wait_mode(tsmc_pkg::TSMC_HIBERNATE, 20);
		xfer(8'h80, 0, 2);
		chk(rd[15:0], 16'hXXXX);
		chk(host_clock_output, 0);
		wake_attention_n = 0;
		repeat (4) @(negedge clock);
		wake_attention_n = 1;
		wait_mode(tsmc_pkg::TSMC_HIB_WAKE, 5);
		repeat (HIBW - 6) @(negedge clock);
		chk(mode, tsmc_pkg::TSMC_HIB_WAKE);
		wait_mode(tsmc_pkg::TSMC_IDLE, 12);
		// fill the buffer with the core stalled, then drain
		wr_ready = 0;
		a = 6'($random(seed)) | 6'h08;
		for (i = 0; i < 5; i++) d[i] = 16'($random(seed));
		xfer({2'b00, a}, {d[0], d[1]}, 4);
		xfer({2'b00, a}, {d[2], d[3]}, 4);
		chk(wr_dropped, 0);
		xfer({2'b00, a}, {d[4], ~d[4]}, 4);
		chk(wr_dropped, 1);
		for (i = 0; i < 5; i++) begin
			chk({wr_valid, wr_word}, {1'b1, a, d[i]});
			wr_ready = 1;
			@(negedge clock);
			wr_ready = 0;
			@(negedge clock);
		end
		chk(wr_valid, 0);
		end_sim();
	end
endmodule

// [test/tsmc_ctrl_sva.sv]
// Purpose: concurrent checks of the serial port and mode control pins
// Assumes: one clock domain, sees top-level ports only
// Notes:   warm-up lengths allow a few cycles of pin latency
module tsmc_ctrl_sva #(
	parameter int OFF_WAKE  = 40,
	parameter int RXTX_WARM = 25
) (
	// clock and reset
	input wire logic                 clock,
	input wire logic                 rst_n,
	// pins
	input wire logic                 select_n,
	input wire logic                 miso_oe,
	input wire logic                 host_clock_output,
	input wire logic                 host_clock_output_oe,
	input wire logic                 irq_request,
	input wire logic                 irq_n,
	input wire logic                 irq_oe,
	// core side
	input wire logic                 wr_valid,
	input wire logic                 wr_ready,
	input wire logic                 rd_strobe,
	input wire tsmc_pkg::tsmc_word_t wr_word,
	input wire tsmc_pkg::tsmc_mode_t mode
);
	tsmc_pkg::tsmc_mode_t prev_q;
	int                   cnt_q;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// cycles spent in the current mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= tsmc_pkg::TSMC_OFF;
			cnt_q  <= 0;
		end else begin
			prev_q <= mode;
			cnt_q  <= (mode == prev_q) ? cnt_q + 1 : 0;
		end
	end

	////////////////////////////////////////////////
	property p_off_quiet; mode == tsmc_pkg::TSMC_OFF |-> !miso_oe && !irq_oe; endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("pin driven in off");
	property p_irq; irq_oe |-> irq_n == !$past(irq_request); endproperty
	a_irq: assert property (p_irq) else $error("irq level wrong");
	property p_off_time; mode == tsmc_pkg::TSMC_IDLE && prev_q == tsmc_pkg::TSMC_OFF
		|-> cnt_q inside {[OFF_WAKE - 3:OFF_WAKE + 2]}; endproperty
	a_off_time: assert property (p_off_time) else $error("off to idle time");
	property p_hib_clk; mode == tsmc_pkg::TSMC_HIBERNATE |-> !host_clock_output; endproperty
	a_hib_clk: assert property (p_hib_clk) else $error("clock out in hibernate");
	property p_idle_clk; (mode == tsmc_pkg::TSMC_IDLE) [*3] |-> host_clock_output_oe; endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("no clock out in idle");
	property p_warm; mode inside {tsmc_pkg::TSMC_RECEIVE, tsmc_pkg::TSMC_TRANSMIT}
		&& prev_q inside {tsmc_pkg::TSMC_RX_WARM, tsmc_pkg::TSMC_TX_WARM}
		|-> cnt_q inside {[RXTX_WARM - 3:RXTX_WARM + 2]}; endproperty
	a_warm: assert property (p_warm) else $error("warm-up time");
	property p_low_cmd; mode inside {tsmc_pkg::TSMC_DOZE, tsmc_pkg::TSMC_HIBERNATE}
		&& prev_q != mode |-> prev_q == tsmc_pkg::TSMC_IDLE && select_n; endproperty
	a_low_cmd: assert property (p_low_cmd) else $error("low power entry");
	property p_miso_rel; select_n [*8] |-> !miso_oe; endproperty
	a_miso_rel: assert property (p_miso_rel) else $error("miso driven unselected");
	property p_wr_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_word); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write word not held");
	property p_rd_strobe; rd_strobe |-> miso_oe && !select_n; endproperty
	a_rd_strobe: assert property (p_rd_strobe) else $error("read fetch outside read");
endmodule

bind tsmc_ctrl tsmc_ctrl_sva #(.OFF_WAKE(OFF_WAKE), .RXTX_WARM(RXTX_WARM)) u_sva (
	.clock, .rst_n, .select_n, .miso_oe, .host_clock_output, .host_clock_output_oe,
	.irq_request, .irq_n, .irq_oe, .wr_valid, .wr_ready, .rd_strobe, .wr_word, .mode);

// [test/tsmc_host.sv]
// Purpose: host serial master making framed transfers into the block
// Assumes: clock polarity and phase zero, most significant bit first
// Notes:   half period may be slowed; mosi turns over once it carries nothing
module tsmc_host (
	// serial pins driven by the host
	output logic      serial_shift_clock,
	output logic      select_n,
	output logic      mosi,
	// read data from the block
	input  wire logic miso,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	int half = 80;

	////////////////////////////////////////////////
	// pins idle, clock low
	initial begin
		serial_shift_clock = 0;
		select_n = 1;
		mosi = 0;
	end

	// select frames header and nb bytes
	task automatic frame(input logic [7:0] hdr, input logic [31:0] pay, input int nb,
		output logic [31:0] rd);
		logic [39:0] bits;
		bits = {hdr, pay};
		rd = 0;
		select_n = 0;
		#100;
		for (int i = 0; i < 8 * (nb + 1); i++) begin
			mosi = (i < 8 || !hdr[7]) ? bits[39 - i] : ~mosi;
			#(half) serial_shift_clock = 1;
			if (i >= 8) rd = {rd[30:0], miso_oe ? miso : 1'bx};
			#(half) serial_shift_clock = 0;
		end
		#100 select_n = 1;
		mosi = ~mosi;
		#100;
	endtask
endmodule
